// ===== logic/sss_pkg.sv
// constants and types shared by the safe stop supervisor
package sss_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] SSS_ADDR_CTRL = 8'h00;
  localparam logic [7:0] SSS_ADDR_DELAY = 8'h04;
  localparam logic [7:0] SSS_ADDR_TOL = 8'h08;
  localparam logic [7:0] SSS_ADDR_SHAPE = 8'h0c;
  localparam logic [7:0] SSS_ADDR_CMD = 8'h10;
  localparam logic [7:0] SSS_ADDR_STATUS = 8'h14;

  // ****************************************
  // field positions
  // ****************************************
  localparam int SSS_FUNC_A_LSB = 0;
  localparam int SSS_FUNC_B_LSB = 2;
  localparam int SSS_STOP_TYPE_BIT = 4;
  localparam int SSS_PROFILE_LSB = 5;
  localparam int SSS_START_RATIO_LSB = 0;
  localparam int SSS_END_RATIO_LSB = 8;
  localparam int SSS_CMD_DOWNLOAD_BIT = 0;
  localparam int SSS_CMD_RESET_BIT = 1;
  localparam int SSS_STAT_OUT_BIT = 3;
  localparam int SSS_STAT_IN_A_BIT = 4;
  localparam int SSS_STAT_IN_B_BIT = 5;
  localparam int SSS_STAT_CAUSE_LSB = 8;

  // ****************************************
  // values after reset and limits
  // ****************************************
  localparam logic [31:0] SSS_CTRL_RST = 32'h0000000e;
  localparam logic [15:0] SSS_DELAY_RST = 16'h000a;
  localparam logic [15:0] SSS_DELAY_MAX = 16'h8ca0;
  localparam logic [7:0] SSS_TOL_RST = 8'h05;
  localparam logic [7:0] SSS_TOL_MAX = 8'h32;
  localparam logic [7:0] SSS_RATIO_RST = 8'h32;
  localparam logic [7:0] SSS_RATIO_MIN = 8'h01;
  localparam logic [7:0] SSS_RATIO_MAX = 8'h63;
  localparam logic [7:0] SSS_PCT_FULL = 8'h64;

  // ****************************************
  // timing
  // ****************************************
  localparam int SSS_CLK_PERIOD_NS = 10;
  localparam int SSS_MS_TIME_NS = 1000000;
  localparam int SSS_MS_CYCLES = (SSS_MS_TIME_NS + SSS_CLK_PERIOD_NS - 1) / SSS_CLK_PERIOD_NS;

  // ****************************************
  // codes
  // ****************************************
  localparam logic [1:0] SSS_RESP_OKAY = 2'h0;
  localparam logic [1:0] SSS_RESP_SLVERR = 2'h2;
  localparam logic [1:0] SSS_PROFILE_LINEAR = 2'h0;
  localparam logic [1:0] SSS_PROFILE_SRAMP = 2'h2;
  localparam logic SSS_TYPE_DELAY = 1'b0;

  typedef enum logic [1:0] {
    SSS_FN_NONE = 2'h0,
    SSS_FN_TORQUE_OFF = 2'h1,
    SSS_FN_STOP = 2'h2,
    SSS_FN_RESET = 2'h3
  } sss_func_t;

  typedef enum logic [2:0] {
    SSS_ST_RUN = 3'b001,
    SSS_ST_STOP = 3'b010,
    SSS_ST_OFF = 3'b100
  } sss_state_t;

endpackage : sss_pkg

// ===== logic/sss_stop_timer.sv
// millisecond stop-delay timer for the safe stop supervisor
`timescale 1ns/1ns
`default_nettype none

module sss_stop_timer
  import sss_pkg::*;
#(
  parameter int MS_CYCLES = SSS_MS_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [22:0] limit_ms,
  output logic expired
);

  logic [31:0] tick_reg;
  logic [22:0] ms_reg;
  logic ms_tick;

  assign ms_tick = (tick_reg == 32'(MS_CYCLES - 1));

  // ****************************************
  // prescaler and millisecond count
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      tick_reg <= 32'h00000000;
    end else if (ms_tick) begin
      tick_reg <= 32'h00000000;
    end else begin
      tick_reg <= tick_reg + 32'h00000001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      ms_reg <= 23'h000000;
    end else if (ms_tick && !expired) begin
      ms_reg <= ms_reg + 23'h000001;
    end
  end

  assign expired = run && (ms_reg >= limit_ms);

endmodule : sss_stop_timer
`default_nettype wire

// ===== logic/sss_supervisor.sv
// safe stop supervisor: torque removal, timed controlled stop, register slave
`timescale 1ns/1ns
`default_nettype none

module sss_supervisor
  import sss_pkg::*;
#(
  parameter int MS_CYCLES = SSS_MS_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic safe_input_a,
  input wire logic safe_input_b,
  input wire logic internal_fault,
  input wire logic drive_uncontrollable,
  input wire logic limit_exceeded,
  input wire logic zero_speed_reached,
  input wire logic drive_running,
  output logic safe_torque_enable_output,
  output logic stop_request,
  output logic [15:0] ramp_time_tenths,
  output logic [1:0] ramp_profile
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] lo,
                                       input logic [7:0] hi);
    logic [7:0] res;
    res = v;
    if (v < lo) begin
      res = lo;
    end else if (v > hi) begin
      res = hi;
    end
    return res;
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  logic [31:0] ctrl_reg;
  logic [15:0] delay_reg;
  logic [7:0] tol_reg;
  logic [7:0] start_ratio_reg;
  logic [7:0] end_ratio_reg;
  logic [4:0] cause_reg;
  logic [4:0] cause_next;
  sss_state_t state_reg;
  sss_state_t state_next;
  logic [1:0] a_sync_reg;
  logic [1:0] b_sync_reg;
  logic a_prev_reg;
  logic b_prev_reg;
  logic a_in;
  logic b_in;
  logic a_fall;
  logic b_fall;
  logic b_rise;
  logic wr_go;
  logic rd_go;
  logic [7:0] wr_addr;
  logic [31:0] wr_val;
  logic [31:0] rd_val;
  logic rd_ok;
  logic wr_ok;
  logic download_pulse;
  logic sw_reset_pulse;
  sss_func_t func_a;
  sss_func_t func_b;
  logic off_level;
  logic stop_edge;
  logic fault_now;
  logic immediate_off;
  logic reset_ok;
  logic timer_run;
  logic timer_done;
  logic [22:0] limit_ms;
  logic [23:0] limit_full;
  logic [31:0] delay_wr;

  assign func_a = sss_func_t'(ctrl_reg[SSS_FUNC_A_LSB +: 2]);
  assign func_b = sss_func_t'(ctrl_reg[SSS_FUNC_B_LSB +: 2]);

  // ****************************************
  // safe input synchronisers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_sync_reg <= 2'h3;
      b_sync_reg <= 2'h3;
    end else begin
      a_sync_reg <= {a_sync_reg[0], safe_input_a};
      b_sync_reg <= {b_sync_reg[0], safe_input_b};
    end
  end

  assign a_in = a_sync_reg[1];
  assign b_in = b_sync_reg[1];

  // history starts at the idle high level so leaving reset makes no edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_prev_reg <= 1'b1;
      b_prev_reg <= 1'b1;
    end else begin
      a_prev_reg <= a_in;
      b_prev_reg <= b_in;
    end
  end

  assign a_fall = a_prev_reg && !a_in;
  assign b_fall = b_prev_reg && !b_in;
  assign b_rise = !b_prev_reg && b_in;

  // ****************************************
  // register bus: write path
  // ****************************************
  // address and data are taken together in one edge
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign wr_addr = s_axi_awaddr;
  assign wr_val = s_axi_wdata;

  always_comb begin
    unique case (wr_addr)
      SSS_ADDR_CTRL, SSS_ADDR_DELAY, SSS_ADDR_TOL, SSS_ADDR_SHAPE, SSS_ADDR_CMD: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SSS_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? SSS_RESP_OKAY : SSS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= SSS_CTRL_RST;
    end else if (wr_go && wr_addr == SSS_ADDR_CTRL) begin
      ctrl_reg <= merge(ctrl_reg, wr_val, s_axi_wstrb) & 32'h0000007f;
    end
  end

  // delay in tenths of a second; zero is kept and means immediate removal
  assign delay_wr = merge({16'h0000, delay_reg}, wr_val, s_axi_wstrb);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      delay_reg <= SSS_DELAY_RST;
    end else if (wr_go && wr_addr == SSS_ADDR_DELAY) begin
      delay_reg <= (delay_wr > {16'h0000, SSS_DELAY_MAX}) ? SSS_DELAY_MAX
                   : delay_wr[15:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tol_reg <= SSS_TOL_RST;
    end else if (wr_go && wr_addr == SSS_ADDR_TOL && s_axi_wstrb[0]) begin
      tol_reg <= clamp(wr_val[7:0], 8'h00, SSS_TOL_MAX);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_ratio_reg <= SSS_RATIO_RST;
      end_ratio_reg <= SSS_RATIO_RST;
    end else if (wr_go && wr_addr == SSS_ADDR_SHAPE) begin
      if (s_axi_wstrb[0]) begin
        start_ratio_reg <= clamp(wr_val[SSS_START_RATIO_LSB +: 8], SSS_RATIO_MIN,
                                 SSS_RATIO_MAX);
      end
      if (s_axi_wstrb[1]) begin
        end_ratio_reg <= clamp(wr_val[SSS_END_RATIO_LSB +: 8], SSS_RATIO_MIN,
                               SSS_RATIO_MAX);
      end
    end
  end

  // command register: write-only pulses
  assign download_pulse = wr_go && wr_addr == SSS_ADDR_CMD && s_axi_wstrb[0]
                          && wr_val[SSS_CMD_DOWNLOAD_BIT];
  assign sw_reset_pulse = wr_go && wr_addr == SSS_ADDR_CMD && s_axi_wstrb[0]
                          && wr_val[SSS_CMD_RESET_BIT];

  // ****************************************
  // register bus: read path
  // ****************************************
  assign rd_go = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_arready = rd_go;

  always_comb begin
    rd_val = 32'h00000000;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      SSS_ADDR_CTRL: rd_val = ctrl_reg;
      SSS_ADDR_DELAY: rd_val = {16'h0000, delay_reg};
      SSS_ADDR_TOL: rd_val = {24'h000000, tol_reg};
      SSS_ADDR_SHAPE: rd_val = {16'h0000, end_ratio_reg, start_ratio_reg};
      SSS_ADDR_CMD: rd_val = 32'h00000000;
      SSS_ADDR_STATUS: begin
        rd_val[2:0] = state_reg;
        rd_val[SSS_STAT_OUT_BIT] = safe_torque_enable_output;
        rd_val[SSS_STAT_IN_A_BIT] = a_in;
        rd_val[SSS_STAT_IN_B_BIT] = b_in;
        rd_val[SSS_STAT_CAUSE_LSB +: 5] = cause_reg;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= SSS_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? SSS_RESP_OKAY : SSS_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // demand decoding
  // ****************************************
  // a torque-off input that is low holds torque off, its fall requests it
  assign off_level = (func_a == SSS_FN_TORQUE_OFF && (!a_in || a_fall))
                     || (func_b == SSS_FN_TORQUE_OFF && (!b_in || b_fall));

  assign stop_edge = (func_a == SSS_FN_STOP && a_fall)
                     || (func_b == SSS_FN_STOP && b_fall);

  assign fault_now = internal_fault || drive_uncontrollable;

  assign immediate_off = fault_now || limit_exceeded
                         || (download_pulse && drive_running)
                         || off_level;

  // reset only with both safe inputs back high and no pending cause
  assign reset_ok = ((func_b == SSS_FN_RESET && b_rise) || sw_reset_pulse)
                    && a_in && b_in && !fault_now && !limit_exceeded;

  // ****************************************
  // stop timer: delay plus tolerance in ms
  // ****************************************
  assign limit_full = 24'(delay_reg) * 24'(SSS_PCT_FULL + tol_reg);
  assign limit_ms = limit_full[22:0];
  assign timer_run = (state_reg == SSS_ST_STOP) && (ctrl_reg[SSS_STOP_TYPE_BIT] == SSS_TYPE_DELAY);

  sss_stop_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(timer_run),
    .limit_ms(limit_ms),
    .expired(timer_done)
  );

  // ****************************************
  // supervisor state machine
  // ****************************************
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SSS_ST_RUN: begin
        if (immediate_off) begin
          state_next = SSS_ST_OFF;
        end else if (stop_edge) begin
          state_next = (delay_reg == 16'h0000) ? SSS_ST_OFF : SSS_ST_STOP;
        end
      end
      SSS_ST_STOP: begin
        if (immediate_off) begin
          state_next = SSS_ST_OFF;
        end else if (ctrl_reg[SSS_STOP_TYPE_BIT] == SSS_TYPE_DELAY) begin
          if (timer_done) begin
            state_next = SSS_ST_OFF;
          end
        end else if (zero_speed_reached) begin
          state_next = SSS_ST_OFF;
        end
      end
      SSS_ST_OFF: begin
        if (reset_ok && !immediate_off) begin
          state_next = SSS_ST_RUN;
        end
      end
      default: state_next = SSS_ST_OFF;
    endcase
  end

  // power-up starts with torque removed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= SSS_ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // cause of the last removal
  // ****************************************
  // bits: 0 fault, 1 limit, 2 download, 3 torque-off input, 4 stop end
  always_comb begin
    cause_next = cause_reg;
    if (state_reg == SSS_ST_OFF && state_next == SSS_ST_RUN) begin
      cause_next = 5'h00;
    end
    if (state_reg != SSS_ST_OFF && state_next == SSS_ST_OFF) begin
      cause_next = cause_next | {!immediate_off, off_level, download_pulse && drive_running,
                                 limit_exceeded, fault_now};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_reg <= 5'h00;
    end else begin
      cause_reg <= cause_next;
    end
  end

  // ****************************************
  // outputs to the drive
  // ****************************************
  // enable feeds the output stage control voltage; low removes torque
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      safe_torque_enable_output <= 1'b0;
      stop_request <= 1'b0;
    end else begin
      safe_torque_enable_output <= (state_next != SSS_ST_OFF);
      stop_request <= (state_next == SSS_ST_STOP);
    end
  end

  // ramp requested from the drive spans the delay time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ramp_time_tenths <= SSS_DELAY_RST;
      ramp_profile <= SSS_PROFILE_LINEAR;
    end else begin
      ramp_time_tenths <= delay_reg;
      ramp_profile <= (ctrl_reg[SSS_PROFILE_LSB +: 2] == SSS_PROFILE_SRAMP)
                      ? SSS_PROFILE_SRAMP : SSS_PROFILE_LINEAR;
    end
  end

endmodule : sss_supervisor
`default_nettype wire

// ===== dv/sss_props.sv
// concurrent checks on the safe stop supervisor ports
`timescale 1ns/1ns
`default_nettype none

module sss_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic internal_fault,
  input wire logic drive_uncontrollable,
  input wire logic limit_exceeded,
  input wire logic safe_torque_enable_output,
  input wire logic stop_request
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence wr_taken;
    s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence stop_entry;
    $rose(stop_request);
  endsequence

  wr_resp_a: assert property (wr_taken |=> s_axi_bvalid) else $error("write not answered");
  rd_resp_a: assert property (rd_taken |=> s_axi_rvalid) else $error("read not answered");
  resp_clear_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not cleared");
  fault_off_a: assert property (internal_fault |=> !safe_torque_enable_output)
    else $error("fault left torque on");
  uncontrol_off_a: assert property (drive_uncontrollable |=> !safe_torque_enable_output)
    else $error("uncontrollable drive left torque on");
  limit_off_a: assert property (limit_exceeded |=> !safe_torque_enable_output)
    else $error("limit left torque on");
  stop_keeps_on_a: assert property (stop_request |-> safe_torque_enable_output)
    else $error("torque off during controlled stop");
  stop_from_run_a: assert property (stop_entry |-> $past(safe_torque_enable_output))
    else $error("controlled stop entered while off");
  stop_ends_off_a: assert property ($fell(stop_request) |-> !safe_torque_enable_output)
    else $error("controlled stop ended with torque on");
  rearm_clean_a: assert property ($rose(safe_torque_enable_output) |->
    !$past(internal_fault) && !$past(limit_exceeded))
    else $error("rearmed during fault");
endmodule // sss_props

bind sss_supervisor sss_props u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .internal_fault(internal_fault),
  .drive_uncontrollable(drive_uncontrollable), .limit_exceeded(limit_exceeded),
  .safe_torque_enable_output(safe_torque_enable_output), .stop_request(stop_request)
);
`default_nettype wire

// ===== dv/sss_drive_model.sv
// behavioural model of the drive power stage behind the supervisor
`timescale 1ns/1ns
`default_nettype none

module sss_drive_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic torque_enable,
  input wire logic stop_request,
  input wire logic slow_brake,
  output logic drive_running,
  output logic zero_speed_reached
);
  logic [3:0] speed_reg;

  // slow_brake makes the drive ignore the ramp and keep turning
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_reg <= 4'h0;
    end else if (torque_enable && !stop_request) begin
      speed_reg <= (speed_reg == 4'hf) ? speed_reg : speed_reg + 4'h1;
    end else if (speed_reg != 4'h0 && (!slow_brake || !torque_enable)) begin
      speed_reg <= speed_reg - 4'h1;
    end
  end

  assign drive_running = (speed_reg != 4'h0);
  assign zero_speed_reached = (speed_reg == 4'h0);
endmodule // sss_drive_model
`default_nettype wire

// ===== dv/sss_supervisor_tb.sv
// self-checking bench for the safe stop supervisor
`timescale 1ns/1ns
`default_nettype none

module sss_supervisor_tb
  import sss_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic safe_input_a = 1'b1, safe_input_b = 1'b1, slow = 1'b0;
  logic internal_fault = 1'b0, drive_uncontrollable = 1'b0, limit_exceeded = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic ten, stop, run, zero;
  logic [1:0] s_axi_bresp, s_axi_rresp, prof;
  logic [31:0] s_axi_rdata;
  logic [15:0] rtime;
  int mismatches = 0;
  int cmp_count = 0;

  always #5 aclk = ~aclk;

  sss_supervisor #(.MS_CYCLES(2)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .safe_input_a, .safe_input_b, .internal_fault,
    .drive_uncontrollable, .limit_exceeded, .zero_speed_reached(zero),
    .drive_running(run), .safe_torque_enable_output(ten), .stop_request(stop),
    .ramp_time_tenths(rtime), .ramp_profile(prof)
  );

  sss_drive_model u_drive (
    .aclk(aclk), .aresetn(aresetn), .torque_enable(ten), .stop_request(stop),
    .slow_brake(slow), .drive_running(run), .zero_speed_reached(zero)
  );

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %0t %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_bvalid);
    chk(s_axi_bresp, er, "write resp");
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    chk(s_axi_rdata, ed, "read data");
    chk(s_axi_rresp, er, "read resp");
    s_axi_rready <= 1'b0;
  endtask

  task automatic wait_ten(input logic v, input int maxc);
    int n;
    n = 0;
    while (ten !== v && n < maxc) begin
      @(posedge aclk);
      n++;
    end
    chk(ten, v, "torque enable");
  endtask

  task automatic arm;
    safe_input_a <= 1'b1;
    safe_input_b <= 1'b1;
    repeat (4) @(posedge aclk);
    wr(SSS_ADDR_CMD, 32'h2, 4'hf, SSS_RESP_OKAY);
    wait_ten(1'b1, 4);
  endtask

  task automatic start_stop;
    int n;
    n = 0;
    safe_input_a <= 1'b0;
    while (stop !== 1'b1 && n < 8) begin
      @(posedge aclk);
      n++;
    end
    chk(stop, 1'b1, "stop request");
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    chk(ten, 1'b0, "enable after reset");
    chk(rtime, 32'h000a, "ramp time");
    rd(SSS_ADDR_CTRL, 32'h0000000e, SSS_RESP_OKAY);
    rd(SSS_ADDR_DELAY, 32'h0000000a, SSS_RESP_OKAY);
    rd(SSS_ADDR_TOL, 32'h00000005, SSS_RESP_OKAY);
    rd(SSS_ADDR_SHAPE, 32'h00003232, SSS_RESP_OKAY);
    rd(SSS_ADDR_CMD, 32'h0, SSS_RESP_OKAY);
    rd(SSS_ADDR_STATUS, 32'h00000034, SSS_RESP_OKAY);
    rd(8'h18, 32'h0, SSS_RESP_SLVERR);
    wr(8'h18, 32'h1, 4'hf, SSS_RESP_SLVERR);
    wr(SSS_ADDR_STATUS, 32'h1, 4'hf, SSS_RESP_SLVERR);
    wr(SSS_ADDR_TOL, 32'hff, 4'hf, SSS_RESP_OKAY);
    rd(SSS_ADDR_TOL, 32'h00000032, SSS_RESP_OKAY);
    wr(SSS_ADDR_DELAY, 32'hffff, 4'hf, SSS_RESP_OKAY);
    rd(SSS_ADDR_DELAY, 32'h00008ca0, SSS_RESP_OKAY);
    chk(rtime, 32'h8ca0, "ramp time clamp");
    wr(SSS_ADDR_SHAPE, 32'h0, 4'h1, SSS_RESP_OKAY);
    rd(SSS_ADDR_SHAPE, 32'h00003201, SSS_RESP_OKAY);
    wr(SSS_ADDR_SHAPE, 32'h6464, 4'hf, SSS_RESP_OKAY);
    rd(SSS_ADDR_SHAPE, 32'h00006363, SSS_RESP_OKAY);
    wr(SSS_ADDR_CTRL, 32'h4e, 4'hf, SSS_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(prof, SSS_PROFILE_SRAMP, "s profile");
    wr(SSS_ADDR_CTRL, 32'h0e, 4'hf, SSS_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(prof, SSS_PROFILE_LINEAR, "linear profile");
    $display("registers done");
  endtask

  task automatic t_timed;
    wr(SSS_ADDR_DELAY, 32'h1, 4'hf, SSS_RESP_OKAY);
    wr(SSS_ADDR_TOL, 32'h32, 4'hf, SSS_RESP_OKAY);
    arm;
    slow <= 1'b1;
    start_stop;
    repeat (285) @(posedge aclk);
    chk(ten, 1'b1, "enable before tolerance ends");
    wait_ten(1'b0, 25);
    chk(run, 1'b1, "drive still turning");
    chk(stop, 1'b0, "stop ended");
    slow <= 1'b0;
    $display("timed stop done");
  endtask

  task automatic t_zero_delay;
    wr(SSS_ADDR_DELAY, 32'h0, 4'hf, SSS_RESP_OKAY);
    arm;
    safe_input_a <= 1'b0;
    wait_ten(1'b0, 6);
    chk(stop, 1'b0, "no stop phase");
    $display("zero delay done");
  endtask

  task automatic t_sto_input;
    wr(SSS_ADDR_DELAY, 32'ha, 4'hf, SSS_RESP_OKAY);
    wr(SSS_ADDR_CTRL, 32'h0d, 4'hf, SSS_RESP_OKAY);
    arm;
    safe_input_a <= 1'b0;
    wait_ten(1'b0, 6);
    chk(stop, 1'b0, "no stop phase");
    wr(SSS_ADDR_CMD, 32'h2, 4'hf, SSS_RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(ten, 1'b0, "rearm with input low");
    arm;
    wr(SSS_ADDR_CTRL, 32'h0e, 4'hf, SSS_RESP_OKAY);
    $display("torque off input done");
  endtask

  task automatic t_preempt;
    arm;
    start_stop;
    internal_fault <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(ten, 1'b0, "fault during stop");
    chk(stop, 1'b0, "stop cancelled");
    wr(SSS_ADDR_CMD, 32'h2, 4'hf, SSS_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(ten, 1'b0, "rearm during fault");
    internal_fault <= 1'b0;
    $display("preempt done");
  endtask

  task automatic t_faults;
    for (int i = 0; i < 2; i++) begin
      arm;
      if (i == 0) begin
        drive_uncontrollable <= 1'b1;
      end else begin
        limit_exceeded <= 1'b1;
      end
      repeat (2) @(posedge aclk);
      chk(ten, 1'b0, "fault input");
      drive_uncontrollable <= 1'b0;
    end
    wr(SSS_ADDR_CMD, 32'h2, 4'hf, SSS_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(ten, 1'b0, "rearm over limit");
    limit_exceeded <= 1'b0;
    $display("faults done");
  endtask

  task automatic t_download;
    arm;
    repeat (20) @(posedge aclk);
    chk(run, 1'b1, "drive running");
    wr(SSS_ADDR_CMD, 32'h1, 4'hf, SSS_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(ten, 1'b0, "download while running");
    $display("download done");
  endtask

  task automatic t_reset_input;
    safe_input_b <= 1'b0;
    repeat (5) @(posedge aclk);
    chk(ten, 1'b0, "held off");
    safe_input_b <= 1'b1;
    wait_ten(1'b1, 8);
    $display("reset input done");
  endtask

  task automatic t_ramp;
    wr(SSS_ADDR_CTRL, 32'h1e, 4'hf, SSS_RESP_OKAY);
    repeat (20) @(posedge aclk);
    start_stop;
    wait_ten(1'b0, 40);
    chk(zero, 1'b1, "off at zero speed");
    $display("ramp stop done");
  endtask

  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_timed;
    t_zero_delay;
    t_sto_input;
    t_preempt;
    t_faults;
    t_download;
    t_reset_input;
    t_ramp;
    summarize;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    summarize;
  end
endmodule // sss_supervisor_tb
`default_nettype wire
